// ===== src/fidp_top.sv
// identification commands and deep power-down of a serial flash
// assumes SPI mode 0/3 host; I_SCK much slower than I_MCLK; I_BUSY from array logic
`timescale 1ns/1ps
`include "fidp_regs.svh"
module fidp_top #(
	parameter logic [7:0] MAKER_ID  = 8'h5A, // arbitrary value
	parameter logic [2:0] FAMILY    = 3'h2,  // arbitrary value
	parameter logic [4:0] DENSITY   = 5'h03, // arbitrary value
	parameter logic [2:0] SUBCODE   = 3'h0,  // arbitrary value
	parameter logic [4:0] VERSION   = 5'h02, // arbitrary value
	parameter logic [7:0] LEGACY_ID = 8'h33  // arbitrary value
) (
	// clock and reset
	input  wire logic       I_MCLK,
	input  wire logic       I_RST_N,
	// serial link pins
	input  wire logic       I_CS_N,
	input  wire logic       I_SCK,
	input  wire logic [3:0] I_IO,
	output logic [3:0]      O_IO,
	output logic [3:0]      O_IO_OE,
	// array state
	input  wire logic       I_BUSY,
	// mode status
	output logic            O_DEEP_PD,
	output logic            O_STANDBY
);
	fidp_pkg::fidp_link_t link;
	fidp_pkg::fidp_cmd_t  cmd_q;
	fidp_pkg::fidp_cmd_t  cmd_d;
	logic [5:0]  cnt_q;
	logic [7:0]  op_q;
	logic        addr_lsb_q;
	logic        pd_q;
	logic        pd_pend_q;
	logic        rs_pend_q;
	logic        out_on_q;
	logic [1:0]  idx_q;
	logic [2:0]  bit_q;
	logic        busy_s1_q;
	logic        busy_q;
	logic        cs_old_q;

	wire         rise      = link.sck_rise & ~link.cs_n;
	wire         fall      = link.sck_fall & ~link.cs_n;
	wire         cs_rel    = link.cs_n & ~cs_old_q;
	wire [7:0]   op_next   = {op_q[6:0], link.io[0]};
	wire         op_done   = (cnt_q == `FIDP_BITS_OPCODE - 6'h01) & rise;
	wire         aligned   = (cnt_q[2:0] == 3'h0);
	wire [7:0]   dev1      = {FAMILY, DENSITY};
	wire [7:0]   dev2      = {SUBCODE, VERSION};
	wire [2:0]   width     = (cmd_q == fidp_pkg::FIDP_QUAD) ? 3'h4 :
		(cmd_q == fidp_pkg::FIDP_DUAL) ? 3'h2 : 3'h1;
	wire [2:0]   last_bit  = 3'h7 / width;
	wire [5:0]   hdr_bits  = (cmd_q == fidp_pkg::FIDP_JEDEC) ? 6'h00 :
		(cmd_q == fidp_pkg::FIDP_DUAL) ? `FIDP_BITS_DUAL_HDR :
		(cmd_q == fidp_pkg::FIDP_QUAD) ? `FIDP_BITS_QUAD_HDR : `FIDP_BITS_DUMMY3;
	wire         hdr_done  = (cnt_q == `FIDP_BITS_OPCODE + hdr_bits);
	wire         reading   = (cmd_q != fidp_pkg::FIDP_IDLE) && (cmd_q != fidp_pkg::FIDP_SKIP);
	wire         start_out = fall & reading & ~out_on_q & hdr_done;
	wire         next_byte = fall & out_on_q & (bit_q == last_bit);
	wire         shift_en  = fall & out_on_q & ~next_byte;
	wire [1:0]   idx_d     = start_out ? 2'h0 : idx_q + 2'h1;
	wire [3:0]   io_bits;

	// byte sequence of each read, indexed by byte count
	function automatic logic [7:0] id_byte(input fidp_pkg::fidp_cmd_t c,
		input logic [1:0] i, input logic swap);
		logic [7:0] b;
		b = MAKER_ID;
		unique case (c)
			fidp_pkg::FIDP_JEDEC:  b = (i == 2'h0) ? MAKER_ID :
				(i == 2'h1) ? dev1 : dev2;
			fidp_pkg::FIDP_LEGACY: b = i[0] ? LEGACY_ID : MAKER_ID;
			fidp_pkg::FIDP_DUAL,
			fidp_pkg::FIDP_QUAD:   b = (i[0] ^ swap) ? LEGACY_ID : MAKER_ID;
			fidp_pkg::FIDP_RESUME: b = LEGACY_ID;
			fidp_pkg::FIDP_IDLE,
			fidp_pkg::FIDP_SKIP:   b = 8'h00;
		endcase
		return b;
	endfunction

	// opcode decode; power-down hears only resume
	function automatic fidp_pkg::fidp_cmd_t decode(input logic [7:0] op, input logic pd);
		fidp_pkg::fidp_cmd_t c;
		c = fidp_pkg::FIDP_SKIP;
		if (op == `FIDP_OP_RESUME)
			c = fidp_pkg::FIDP_RESUME;
		else if (!pd) begin
			if (op == `FIDP_OP_JEDEC_ID)
				c = fidp_pkg::FIDP_JEDEC;
			else if (op == `FIDP_OP_LEGACY_ID)
				c = fidp_pkg::FIDP_LEGACY;
			else if (op == `FIDP_OP_DUAL_ID)
				c = fidp_pkg::FIDP_DUAL;
			else if (op == `FIDP_OP_QUAD_ID)
				c = fidp_pkg::FIDP_QUAD;
		end
		return c;
	endfunction

	fidp_sync u_sync (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RST_N),
		.i_cs_n  (I_CS_N),
		.i_sck   (I_SCK),
		.i_io    (I_IO),
		.o_link  (link)
	);

	fidp_shift u_shift (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RST_N),
		.i_load  (start_out | next_byte),
		.i_shift (shift_en),
		.i_width (width),
		.i_byte  (id_byte(cmd_q, start_out ? 2'h0 : idx_d, addr_lsb_q)),
		.o_bits  (io_bits)
	);

	assign cmd_d = op_done ? decode(op_next, pd_q) : cmd_q;

	// busy comes from the array logic on its own timing, so it is synchronised
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			busy_s1_q <= 1'b0;
			busy_q    <= 1'b0;
		end else begin
			busy_s1_q <= I_BUSY;
			busy_q    <= busy_s1_q;
		end
	end

	// command capture; count stops wrapping, low bits keep byte alignment
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cnt_q      <= 6'h00;
			op_q       <= 8'h00;
			cmd_q      <= fidp_pkg::FIDP_IDLE;
			addr_lsb_q <= 1'b0;
			pd_pend_q  <= 1'b0;
			rs_pend_q  <= 1'b0;
		end else if (link.cs_n) begin
			cnt_q      <= 6'h00;
			cmd_q      <= fidp_pkg::FIDP_IDLE;
			addr_lsb_q <= 1'b0;
			pd_pend_q  <= 1'b0;
			rs_pend_q  <= 1'b0;
		end else if (rise) begin
			cnt_q <= (cnt_q[5:3] == 3'h7) ? {3'h7, cnt_q[2:0] + 3'h1} : cnt_q + 6'h01;
			if (cnt_q < `FIDP_BITS_OPCODE)
				op_q <= op_next;
			cmd_q <= cmd_d;
			if (op_done) begin
				pd_pend_q <= (op_next == `FIDP_OP_POWERDOWN) & ~pd_q & ~busy_q;
				rs_pend_q <= (op_next == `FIDP_OP_RESUME) & pd_q;
			end
			// last address bit: single line for dual/quad low nibble lane 0
			if (cnt_q == `FIDP_BITS_OPCODE + hdr_bits - 6'h01 - ((cmd_q ==
				fidp_pkg::FIDP_QUAD) ? 6'h04 : 6'h00) && (cmd_q == fidp_pkg::FIDP_DUAL
				|| cmd_q == fidp_pkg::FIDP_QUAD))
				addr_lsb_q <= link.io[0];
		end
	end

	// power-down state: entered or left only on an aligned chip select release
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pd_q <= 1'b0;
		end else if (cs_rel && aligned) begin
			if (pd_pend_q)
				pd_q <= 1'b1;
			else if (rs_pend_q)
				pd_q <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N)
			cs_old_q <= 1'b1;
		else
			cs_old_q <= link.cs_n;
	end

	// output sequencing on falling edges
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			out_on_q <= 1'b0;
			idx_q    <= 2'h0;
			bit_q    <= 3'h0;
		end else if (link.cs_n) begin
			out_on_q <= 1'b0;
			idx_q    <= 2'h0;
			bit_q    <= 3'h0;
		end else if (start_out || next_byte) begin
			out_on_q <= 1'b1;
			idx_q    <= (cmd_q == fidp_pkg::FIDP_JEDEC && idx_d == 2'h3) ? 2'h2 : idx_d;
			bit_q    <= 3'h0;
		end else if (shift_en) begin
			bit_q    <= bit_q + 3'h1;
		end
	end

	// lanes enabled by width; chip select high floats at once
	// single mode moves the bit onto the serial output lane
	assign O_IO    = (width == 3'h1) ? {2'h0, io_bits[0], 1'b0} : io_bits;
	assign O_IO_OE = (out_on_q && !link.cs_n) ? ((width == 3'h4) ? 4'hF :
		(width == 3'h2) ? 4'h3 : 4'h2) : 4'h0;
	assign O_DEEP_PD = pd_q;
	assign O_STANDBY = link.cs_n & ~busy_q & ~pd_q;

	property p_pd_reset;
		@(posedge I_MCLK) $rose(I_RST_N) |-> !pd_q;
	endproperty
	a_pd_reset: assert property (p_pd_reset) else $error("power-down after reset");
	property p_float;
		@(posedge I_MCLK) disable iff (!I_RST_N) link.cs_n |-> O_IO_OE == 4'h0;
	endproperty
	a_float: assert property (p_float) else $error("driving while deselected");
	property p_busy_pd;
		@(posedge I_MCLK) disable iff (!I_RST_N) (rise && op_done && busy_q) |=> !pd_pend_q;
	endproperty
	a_busy_pd: assert property (p_busy_pd) else $error("power-down taken while busy");
	property p_pd_hear;
		@(posedge I_MCLK) disable iff (!I_RST_N) (op_done && pd_q &&
			op_next != `FIDP_OP_RESUME) |=> cmd_q == fidp_pkg::FIDP_SKIP;
	endproperty
	a_pd_hear: assert property (p_pd_hear) else $error("command heard in power-down");
	property p_enter;
		@(posedge I_MCLK) disable iff (!I_RST_N) (cs_rel && aligned && pd_pend_q) |=> pd_q;
	endproperty
	a_enter: assert property (p_enter) else $error("power-down not entered");
	property p_abort;
		@(posedge I_MCLK) disable iff (!I_RST_N) (cs_rel && !aligned && !pd_q) |=> !pd_q;
	endproperty
	a_abort: assert property (p_abort) else $error("misaligned power-down taken");
	property p_resume;
		@(posedge I_MCLK) disable iff (!I_RST_N) (cs_rel && aligned && rs_pend_q) |=> !pd_q;
	endproperty
	a_resume: assert property (p_resume) else $error("resume not taken");
	property p_edge;
		@(posedge I_MCLK) disable iff (!I_RST_N) !link.sck_fall |=> $stable(io_bits);
	endproperty
	a_edge: assert property (p_edge) else $error("output changed off falling edge");
	property p_standby;
		@(posedge I_MCLK) disable iff (!I_RST_N) (link.cs_n && !busy_q && !pd_q) |-> O_STANDBY;
	endproperty
	a_standby: assert property (p_standby) else $error("standby missing");
	// header bits still owed, so nothing may be driven yet
	sequence s_hdr_pending;
		fall && reading && !out_on_q && !hdr_done;
	endsequence
	property p_wait_hdr;
		@(posedge I_MCLK) disable iff (!I_RST_N) s_hdr_pending |=> !out_on_q;
	endproperty
	a_wait_hdr: assert property (p_wait_hdr) else $error("output before header end");
	sequence s_first_load;
		start_out && (cmd_q == fidp_pkg::FIDP_JEDEC || cmd_q == fidp_pkg::FIDP_LEGACY);
	endsequence
	property p_maker_first;
		@(posedge I_MCLK) disable iff (!I_RST_N) s_first_load |=> io_bits[0] == MAKER_ID[7];
	endproperty
	a_maker_first: assert property (p_maker_first) else $error("maker byte not first");
	sequence s_swap_load;
		start_out && addr_lsb_q && cmd_q == fidp_pkg::FIDP_DUAL;
	endsequence
	property p_swap;
		@(posedge I_MCLK) disable iff (!I_RST_N) s_swap_load |=> io_bits[1:0] == LEGACY_ID[7:6];
	endproperty
	a_swap: assert property (p_swap) else $error("device byte not first");
	property p_pair;
		@(posedge I_MCLK) disable iff (!I_RST_N) (next_byte && cmd_q == fidp_pkg::FIDP_LEGACY
			&& idx_q[0]) |=> io_bits[0] == MAKER_ID[7];
	endproperty
	a_pair: assert property (p_pair) else $error("legacy pair not repeated");
	property p_lanes_dual;
		@(posedge I_MCLK) disable iff (!I_RST_N) (out_on_q && !link.cs_n &&
			cmd_q == fidp_pkg::FIDP_DUAL) |-> O_IO_OE == 4'h3;
	endproperty
	a_lanes_dual: assert property (p_lanes_dual) else $error("dual lanes not driven");
	property p_lanes_quad;
		@(posedge I_MCLK) disable iff (!I_RST_N) (out_on_q && !link.cs_n &&
			cmd_q == fidp_pkg::FIDP_QUAD) |-> O_IO_OE == 4'hF;
	endproperty
	a_lanes_quad: assert property (p_lanes_quad) else $error("quad lanes not driven");
endmodule

// ===== pkg/fidp_regs.svh
// constants of the flash identification and deep power-down logic
// assumes inclusion by the top-level design file only
`ifndef FIDP_REGS_SVH
`define FIDP_REGS_SVH
`define FIDP_OP_JEDEC_ID   8'h9F
`define FIDP_OP_LEGACY_ID  8'h90
`define FIDP_OP_DUAL_ID    8'h92
`define FIDP_OP_QUAD_ID    8'h94
`define FIDP_OP_POWERDOWN  8'hB9
`define FIDP_OP_RESUME     8'hAB
`define FIDP_BITS_OPCODE   6'h08
`define FIDP_BITS_DUMMY3   6'h18
`define FIDP_BITS_DUAL_HDR 6'h18
`define FIDP_BITS_QUAD_HDR 6'h1C
`define FIDP_FAMILY_POS    5
`define FIDP_SUBCODE_POS   5
`endif

// ===== pkg/fidp_pkg.sv
// types of the flash identification and deep power-down logic
// assumes fidp_regs.svh for the constants
package fidp_pkg;
	typedef enum logic [2:0] {
		FIDP_IDLE,
		FIDP_SKIP,
		FIDP_JEDEC,
		FIDP_LEGACY,
		FIDP_DUAL,
		FIDP_QUAD,
		FIDP_RESUME
	} fidp_cmd_t;
	typedef struct packed {
		logic       cs_n;
		logic       sck_rise;
		logic       sck_fall;
		logic [3:0] io;
	} fidp_link_t;
endpackage

// ===== src/fidp_sync.sv
// two-flip-flop synchroniser plus edge detection of the serial clock
// assumes pins from outside the I_MCLK domain
`timescale 1ns/1ps
module fidp_sync (
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	// pins
	input  wire logic                i_cs_n,
	input  wire logic                i_sck,
	input  wire logic [3:0]          i_io,
	// synchronised view
	output fidp_pkg::fidp_link_t     o_link
);
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic       sck_old_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q      <= 6'h01;
			s2_q      <= 6'h01;
			sck_old_q <= 1'b0;
		end else begin
			s1_q      <= {i_sck, i_io, i_cs_n};
			s2_q      <= s1_q;
			sck_old_q <= s2_q[5];
		end
	end
	assign o_link.cs_n     = s2_q[0];
	assign o_link.io       = s2_q[4:1];
	assign o_link.sck_rise = s2_q[5] & ~sck_old_q;
	assign o_link.sck_fall = ~s2_q[5] & sck_old_q;
endmodule

// ===== src/fidp_shift.sv
// output shifter: presents id bytes msb first, 1, 2 or 4 bits per fall
// assumes loads and shifts come on falling serial clock edges
`timescale 1ns/1ps
module fidp_shift (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// control
	input  wire logic       i_load,
	input  wire logic       i_shift,
	input  wire logic [2:0] i_width,
	input  wire logic [7:0] i_byte,
	// data
	output logic [3:0]      o_bits
);
	logic [7:0] sr_q;
	logic [7:0] sr_d;
	logic [3:0] out_q;
	logic [3:0] out_d;
	assign sr_d  = i_load ? i_byte : (sr_q << i_width);
	assign out_d = (i_width == 3'h4) ? sr_d[7:4] :
		(i_width == 3'h2) ? {2'h0, sr_d[7:6]} : {3'h0, sr_d[7]};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sr_q  <= 8'h00;
			out_q <= 4'h0;
		end else if (i_load || i_shift) begin
			sr_q  <= sr_d;
			out_q <= out_d;
		end
	end
	assign o_bits = out_q;
endmodule

// ===== tb/fidp_host.sv
// behavioural spi host driving flash commands in mode 0
// assumes the bench calls its tasks; i_io is the resolved data wires
`timescale 1ns/1ps
module fidp_host (
	// clock
	input  wire logic       i_clk,
	// wires
	input  wire logic [3:0] i_io,
	output logic            o_cs_n,
	output logic            o_sck,
	output logic [3:0]      o_io
);
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_io   = 4'h5;
	end
	// half of an 800 ns serial clock; slow rate while the part is unknown
	task automatic half();
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task automatic sel();
		@(posedge i_clk);
		#1;
		o_cs_n = 1'b0;
		half();
	endtask
	// released wires show the inverse, not the last value
	task automatic desel();
		half();
		o_cs_n = 1'b1;
		o_io = ~o_io;
		half();
		half();
	endtask
	// opcode, address, dummies and data msb first; sample before each rise
	task automatic xfer(input logic [31:0] d, input int n, input int w,
		output logic [31:0] r);
		r = 32'h0;
		for (int i = 0; i < n; i++) begin
			o_io = {{3{~d[n-1-i]}}, d[n-1-i]};
			half();
			if (w == 1)
				r = {r[30:0], i_io[1]};
			else if (w == 2)
				r = {r[29:0], i_io[1:0]};
			else
				r = {r[27:0], i_io};
			o_sck = 1'b1;
			half();
			o_sck = 1'b0;
		end
	endtask
endmodule

// ===== tb/fidp_top_tb.sv
// self-checking bench of the flash identification and power-down logic
// assumes fidp_host as the far side; expected ids from bench parameters
`timescale 1ns/1ps
module fidp_top_tb;
	localparam logic [7:0]  MK  = 8'h5A; // arbitrary value
	localparam logic [7:0]  LG  = 8'h33; // arbitrary value
	localparam logic [23:0] JID = {MK, 3'h2, 5'h03, 3'h0, 5'h02};
	logic        mclk;
	logic        rst_n;
	logic        busy;
	logic        pd;
	logic        stby;
	logic        cs_n;
	logic        sck;
	logic [3:0]  hio;
	logic [3:0]  dio;
	logic [3:0]  oe;
	logic [3:0]  wio;
	logic [31:0] r;
	int          error_cnt = 0;
	int          check_count = 0;
	int          cyc = 0;
	assign wio = (oe & dio) | (~oe & hio);
	fidp_top #(.MAKER_ID(MK), .FAMILY(3'h2), .DENSITY(5'h03), .SUBCODE(3'h0),
		.VERSION(5'h02), .LEGACY_ID(LG)) u_fidp_top (
		.I_MCLK(mclk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCK(sck), .I_IO(wio),
		.O_IO(dio), .O_IO_OE(oe), .I_BUSY(busy), .O_DEEP_PD(pd), .O_STANDBY(stby));
	fidp_host u_fidp_host (.i_clk(mclk), .i_io(wio), .o_cs_n(cs_n), .o_sck(sck),
		.o_io(hio));
	initial mclk = 1'b0;
	always #50 mclk = ~mclk;
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// whole run is a few thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input int hn, input logic hv);
		u_fidp_host.sel();
		u_fidp_host.xfer({24'h0, op}, 8, 1, r);
		if (hn > 0)
			u_fidp_host.xfer({32{hv}}, hn, 1, r);
	endtask
	task automatic t_jedec();
		cmd(8'h9F, 0, 1'b0);
		u_fidp_host.xfer(32'h0, 24, 1, r);
		chk(r, {8'h0, JID}, "jedec id");
		chk(oe, 4'h2, "single enable");
		chk(stby, 1'b0, "selected standby");
		u_fidp_host.xfer(32'h0, 4, 1, r);
		u_fidp_host.desel();
		chk(oe, 4'h0, "mid-byte release");
		chk(stby, 1'b1, "standby");
	endtask
	task automatic t_legacy();
		cmd(8'h90, 24, 1'b0);
		u_fidp_host.xfer(32'h0, 32, 1, r);
		chk(r, {MK, LG, MK, LG}, "legacy pairs");
		u_fidp_host.desel();
		chk(oe, 4'h0, "legacy release");
	endtask
	// dual and quad id reads with address lsb a
	task automatic t_multi(input logic [7:0] op, input int hn, input int w,
		input logic a, input logic [15:0] exp, input logic [3:0] oe_exp);
		cmd(op, 0, 1'b0);
		u_fidp_host.xfer({31'h0, a}, 24, 1, r);
		if (hn > 24)
			u_fidp_host.xfer(32'h0, hn - 24, 1, r);
		u_fidp_host.xfer(32'h0, 16 / w, w, r);
		chk(r, {16'h0, exp}, "multi-line id");
		chk(oe, oe_exp, "multi-line enable");
		u_fidp_host.desel();
	endtask
	task automatic t_pd();
		@(posedge mclk);
		#1;
		busy = 1'b1;
		cmd(8'hB9, 0, 1'b0);
		u_fidp_host.desel();
		chk(pd, 1'b0, "busy power-down");
		chk(stby, 1'b0, "busy not standby");
		busy = 1'b0;
		u_fidp_host.sel();
		u_fidp_host.xfer(32'h5C, 7, 1, r);
		u_fidp_host.desel();
		chk(pd, 1'b0, "short opcode");
		u_fidp_host.sel();
		u_fidp_host.xfer(32'hB90, 12, 1, r);
		u_fidp_host.desel();
		chk(pd, 1'b0, "misaligned release");
		cmd(8'hB9, 8, 1'b1);
		u_fidp_host.desel();
		chk(pd, 1'b1, "power-down entered");
		chk(stby, 1'b0, "power-down not standby");
		cmd(8'h9F, 0, 1'b0);
		u_fidp_host.xfer(32'h0, 8, 1, r);
		chk(oe, 4'h0, "ignored in power-down");
		u_fidp_host.desel();
		chk(pd, 1'b1, "still power-down");
		cmd(8'hAB, 24, 1'b0);
		u_fidp_host.xfer(32'h0, 16, 1, r);
		chk(r, {16'h0, LG, LG}, "resume id");
		u_fidp_host.desel();
		chk(pd, 1'b0, "resumed");
		chk(stby, 1'b1, "resumed standby");
	endtask
	initial begin
		rst_n = 1'b0;
		busy = 1'b0;
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge mclk);
		chk(pd, 1'b0, "reset power-down");
		chk(stby, 1'b1, "reset standby");
		t_jedec();
		t_legacy();
		t_multi(8'h92, 24, 2, 1'b0, {MK, LG}, 4'h3);
		t_multi(8'h92, 24, 2, 1'b1, {LG, MK}, 4'h3);
		t_multi(8'h94, 28, 4, 1'b0, {MK, LG}, 4'hF);
		t_multi(8'h94, 28, 4, 1'b1, {LG, MK}, 4'hF);
		t_pd();
		wrap_up();
	end
endmodule
